// ---- verilog/ers_defs.vh ----
// Constants for the memory readout serializer
`ifndef ERS_DEFS_VH
`define ERS_DEFS_VH

// ==========================================
// Register map, byte addresses
`define ERS_REG_CTRL        8'h00
`define ERS_REG_STATUS      8'h04
`define ERS_REG_WADDR       8'h08
`define ERS_REG_WDATA       8'h0c
`define ERS_REG_TX          8'h10
`define ERS_REG_CFG         8'h14

// ==========================================
// Commands and bit fields
`define ERS_CMD_READ        8'h00
`define ERS_MEM_BITS        152
`define ERS_MEM_BYTES       19
`define ERS_TOTAL_BYTES     5'h14
`define ERS_MARKER          8'ha5
`define ERS_LOCK_HI         105
`define ERS_LOCK_LO         103
`define ERS_LOCK_A          3'h6
`define ERS_LOCK_B          3'h3
`define ERS_SIG_LO          144
`define ERS_TRIM_LO         3
`define ERS_LIM_LO          15
`define ERS_OSEL_LO         11
`define ERS_MODE_ABS1V      2'h1
`define ERS_MODE_DIGITAL    2'h2

`endif

// ---- verilog/ers_serializer.v ----
// Memory readout serializer with write, signature and output configuration decode
// What this block does
// - Read command code 00 hex streams the whole memory as consecutive bytes out on the tx_byte valid/ready handshake.
// - After each byte the memory image is shifted by eight bits so the next byte follows.
// - Bytes 1 to 19 carry the packed memory fields in order and byte 20 is the constant A5 hex.
// - In digital output mode the source select chooses bridge alone or bridge with temperature.
// - The limiter configuration at memory bits 16:15 sets the external transistor regulation level.
// - In absolute one-volt mode the 4-bit trim field trims the output voltage reference.
// - In ratiometric mode the same 4-bit trim field trims the regulator reference instead.
// - A lock field at bits 105:103 of 6 or 3 hex blocks further memory writes until a reset clears the memory.
// - The signature byte is recomputed and stored after every memory write.
`timescale 1ns/1ps
`default_nettype none
`include "ers_defs.vh"

module ers_serializer (
   input  wire         sys_clk,
   input  wire         reset,
   input  wire [7:0]   addr,
   input  wire [31:0]  wdata,
   input  wire         wr_en,
   input  wire         rd_en,
   output reg  [31:0]  rdata,
   input  wire         cmd_valid,
   input  wire [7:0]   cmd_code,
   input  wire         tx_ready,
   output reg          tx_valid,
   output reg  [7:0]   tx_byte,
   output reg          tx_last,
   output reg          busy,
   output reg          out_temp_enable,
   output reg  [1:0]   limiter_config,
   output reg  [3:0]   abs_ref_trim,
   output reg  [3:0]   reg_ref_trim,
   output reg          write_locked
);

   // ==========================================
   // State
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SEND = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   reg [2:0]                     state;
   reg [`ERS_MEM_BITS-1:0]       mem;
   reg [`ERS_MEM_BITS-1:0]       shift_img;
   reg [4:0]                     byte_cnt;
   reg [4:0]                     waddr;
   reg                           sig_pending;

   // ==========================================
   // Helpers
   // Signature is an xor of all data bytes below the signature field
   function [7:0] sig_calc;
      input [`ERS_MEM_BITS-1:0] m;
      integer i;
      begin
         sig_calc = 8'h00;
         for (i = 0; i < 18; i = i + 1) begin
            sig_calc = sig_calc ^ m[i*8 +: 8];
         end
      end
   endfunction

   function lock_hit;
      input [2:0] f;
      begin
         lock_hit = (f == `ERS_LOCK_A) || (f == `ERS_LOCK_B);
      end
   endfunction

   wire [2:0] lock_field = mem[`ERS_LOCK_HI:`ERS_LOCK_LO];
   wire [1:0] out_mode   = mem[`ERS_OSEL_LO+1:`ERS_OSEL_LO];
   wire [3:0] trim_field = mem[`ERS_TRIM_LO+3:`ERS_TRIM_LO];
   wire       data_wr    = wr_en && (addr == `ERS_REG_WDATA);
   wire       waddr_wr   = wr_en && (addr == `ERS_REG_WADDR);
   wire       wr_accept  = data_wr && !lock_hit(lock_field) && (state == ST_IDLE)
                           && (waddr < 5'd18);
   // A read command beside a data write would capture a half-updated image
   wire       start_read = cmd_valid && (cmd_code == `ERS_CMD_READ) && (state == ST_IDLE)
                           && !sig_pending && !data_wr;

   // ==========================================
   // Memory write path and signature update
   reg [`ERS_MEM_BITS-1:0]       next_mem;
   reg [4:0]                     next_waddr;
   reg                           next_sig_pending;

   always @* begin
      next_mem         = mem;
      next_waddr       = waddr;
      next_sig_pending = 1'b0;
      if (waddr_wr) begin
         next_waddr = wdata[4:0];
      end
      // Writes are refused while a readout runs so the image stays coherent
      if (wr_accept) begin
         next_mem[waddr*8 +: 8] = wdata[7:0];
         next_sig_pending       = 1'b1;
      end
      // A write beside the update sets the flag again, so the signature is redone
      if (sig_pending) begin
         next_mem[`ERS_SIG_LO +: 8] = sig_calc(mem);
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         mem         <= {`ERS_MEM_BITS{1'b0}};
         waddr       <= 5'h00;
         sig_pending <= 1'b0;
      end else begin
         mem         <= next_mem;
         waddr       <= next_waddr;
         sig_pending <= next_sig_pending;
      end
   end

   // ==========================================
   // Readout sequencer
   reg [2:0]                     next_state;
   reg [`ERS_MEM_BITS-1:0]       next_shift_img;
   reg [4:0]                     next_byte_cnt;
   reg                           next_tx_valid;
   reg [7:0]                     next_tx_byte;
   reg                           next_tx_last;
   reg                           next_busy;
   wire                          last_slot = (byte_cnt == `ERS_TOTAL_BYTES - 5'h01);
   wire                          accepted  = tx_valid && tx_ready;

   always @* begin
      next_state     = state;
      next_shift_img = shift_img;
      next_byte_cnt  = byte_cnt;
      next_tx_valid  = tx_valid;
      next_tx_byte   = tx_byte;
      next_tx_last   = tx_last;
      next_busy      = busy;
      case (state)
         ST_IDLE: begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            // A pending signature update finishes before the image is captured
            if (start_read) begin
               next_shift_img = mem;
               next_byte_cnt  = 5'h00;
               next_busy      = 1'b1;
               next_state     = ST_SEND;
            end
         end
         ST_SEND: begin
            next_tx_valid = 1'b1;
            next_state    = ST_WAIT;
            if (last_slot) begin
               next_tx_byte = `ERS_MARKER;
               next_tx_last = 1'b1;
            end else begin
               next_tx_byte = shift_img[7:0];
               next_tx_last = 1'b0;
            end
         end
         ST_WAIT: begin
            // Byte and flags stand until the host takes them
            if (accepted) begin
               next_tx_valid  = 1'b0;
               next_shift_img = shift_img >> 8;
               next_byte_cnt  = byte_cnt + 5'h01;
               if (tx_last) begin
                  next_tx_last = 1'b0;
                  next_busy    = 1'b0;
                  next_state   = ST_IDLE;
               end else begin
                  next_state = ST_SEND;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         state     <= ST_IDLE;
         shift_img <= {`ERS_MEM_BITS{1'b0}};
         byte_cnt  <= 5'h00;
         tx_valid  <= 1'b0;
         tx_byte   <= 8'h00;
         tx_last   <= 1'b0;
         busy      <= 1'b0;
      end else begin
         state     <= next_state;
         shift_img <= next_shift_img;
         byte_cnt  <= next_byte_cnt;
         tx_valid  <= next_tx_valid;
         tx_byte   <= next_tx_byte;
         tx_last   <= next_tx_last;
         busy      <= next_busy;
      end
   end

   // ==========================================
   // Configuration decode outputs
   always @(posedge sys_clk) begin
      if (reset) begin
         out_temp_enable <= 1'b0;
         limiter_config  <= 2'h0;
         abs_ref_trim    <= 4'h0;
         reg_ref_trim    <= 4'h0;
         write_locked    <= 1'b0;
      end else begin
         // Only bit 2 of the select matters in digital mode
         out_temp_enable <= (out_mode == `ERS_MODE_DIGITAL) && mem[`ERS_OSEL_LO+2];
         limiter_config  <= mem[`ERS_LIM_LO+1:`ERS_LIM_LO];
         abs_ref_trim    <= (out_mode == `ERS_MODE_ABS1V) ? trim_field : 4'h0;
         reg_ref_trim    <= (out_mode == `ERS_MODE_ABS1V) ? 4'h0 : trim_field;
         write_locked    <= lock_hit(lock_field);
      end
   end

   // ==========================================
   // Register read port
   always @(posedge sys_clk) begin
      if (reset) begin
         rdata <= 32'h00000000;
      end else if (rd_en) begin
         case (addr)
            `ERS_REG_STATUS: rdata <= {24'h000000, byte_cnt, write_locked, sig_pending, busy};
            `ERS_REG_WADDR:  rdata <= {27'h0000000, waddr};
            `ERS_REG_WDATA:  rdata <= {24'h000000, mem[waddr*8 +: 8]};
            `ERS_REG_TX:     rdata <= {23'h000000, tx_valid, tx_byte};
            `ERS_REG_CFG:    rdata <= {20'h00000, abs_ref_trim, reg_ref_trim,
                                       limiter_config, out_mode};
            default:         rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// ---- verification/ers_checker.sv ----
// Port assertions for the readout serializer
`timescale 1ns/1ps
`default_nettype none
module ers_checker (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       tx_ready,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic       tx_last,
   input wire logic       busy,
   input wire logic [1:0] limiter_config,
   input wire logic       write_locked
);
   // =====
   // Stream and decode
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("byte not held");
   a_gap_after: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("no gap");
   a_last_marker: assert property (tx_last |-> tx_valid && tx_byte == 8'ha5)
      else $error("bad marker");
   a_tx_in_busy: assert property (tx_valid |-> busy)
      else $error("idle send");
   a_start_gap: assert property ($rose(busy) |-> !tx_valid ##1 tx_valid)
      else $error("late start");
   a_run_end: assert property (tx_valid && tx_ready && tx_last |-> ##[1:2] !busy)
      else $error("busy stuck");
   a_lock_sticks: assert property (write_locked |=> write_locked)
      else $error("lock lost");
   a_cfg_frozen: assert property (busy && $past(busy) |-> $stable(limiter_config))
      else $error("cfg moved");
   c_last: cover property (tx_last && tx_ready);
   c_stall: cover property (tx_valid && !tx_ready);
   c_lock: cover property (write_locked);
endmodule
bind ers_serializer ers_checker chk (.*);
`default_nettype wire

// ---- verification/ers_host.sv ----
// Host model that takes streamed bytes
`timescale 1ns/1ps
`default_nettype none
module ers_host (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       slow,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic       tx_last,
   output var logic       tx_ready
);
   logic [7:0] rx [0:63];
   logic [5:0] cnt;
   logic [2:0] ph;
   logic       bad;
   // =====
   // Slow mode stalls five cycles of eight
   always @(posedge sys_clk) begin
      if (reset) begin
         {tx_ready, cnt, ph, bad} <= 11'h0;
      end else begin
         ph <= ph + 3'h1;
         tx_ready <= !slow || ph > 3'h4;
         if (tx_valid && tx_ready) begin
            rx[cnt] <= tx_byte;
            cnt <= cnt + 6'h1;
            bad <= bad || (tx_last && tx_byte !== 8'ha5);
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the readout serializer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        sys_clk = 0, reset = 1, wr_en = 0, rd_en = 0, cmd_valid = 0, slow = 0;
   logic [7:0]  addr = 0, cmd_code = 0, tx_byte, mem [0:19];
   logic [31:0] wdata = 0, rdata, r;
   logic        tx_ready, tx_valid, tx_last, busy, out_temp_enable, write_locked;
   logic [1:0]  limiter_config;
   logic [3:0]  abs_ref_trim, reg_ref_trim;
   logic [8:0]  rows [0:3] = '{9'h0aa, 9'h155, 9'h10f, 9'h030};
   int          error_cnt = 0, samples_checked = 0, i, k, n;
   ers_serializer dut (.*);
   ers_host host (.*);
   initial forever #50 sys_clk = ~sys_clk;
   // =====
   // Bus tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {addr, wdata, wr_en} <= {a, d, 1'h1};
      @(posedge sys_clk);
      wr_en <= 1'h0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      {addr, rd_en} <= {a, 1'h1};
      @(posedge sys_clk);
      rd_en <= 1'h0;
      #1 r = rdata;
   endtask
   // Shadow signature follows every accepted write
   task wm(input int j, input logic [7:0] d);
      wr(8'h08, j);
      wr(8'h0c, {24'h0, d});
      mem[j] = d;
      mem[18] = 8'h00;
      for (k = 0; k < 18; k++) mem[18] ^= mem[k];
   endtask
   task run(input logic [7:0] c, input logic s);
      slow <= s;
      n = host.cnt;
      @(posedge sys_clk);
      {cmd_valid, cmd_code} <= {1'h1, c};
      @(posedge sys_clk);
      cmd_valid <= 1'h0;
      for (i = 0; i < 3000 && host.cnt != n + 20 && c == 8'h00; i++) @(posedge sys_clk);
      if (i == 3000) begin
         error_cnt++;
         print_verdict;
      end
      repeat (3) @(posedge sys_clk);
      if (c != 8'h00) chk(busy, 0);
      else for (k = 0; k < 20; k++) chk(host.rx[n + k], mem[k]);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      mem[19] = 8'ha5;
      repeat (10) @(posedge sys_clk);
      reset <= 1'h0;
      @(posedge sys_clk);
      #1 chk({busy, tx_valid, write_locked}, 0);
      $display("reset test done");
      for (i = 0; i < 18; i++) wm(i, 8'h40 + 8'(i));
      for (i = 0; i < 4; i++) begin
         wm(0, {1'h0, rows[i][5:2], 3'h0});
         wm(1, {rows[i][0], 1'h0, rows[i][6], rows[i][8:7], 3'h0});
         wm(2, {7'h0, rows[i][1]});
         repeat (4) @(posedge sys_clk);
         chk(limiter_config, rows[i][1:0]);
         if (rows[i][8:7] == 2'h1) chk(abs_ref_trim, rows[i][5:2]);
         if (rows[i][8:7] == 2'h0) chk(reg_ref_trim, rows[i][5:2]);
         if (rows[i][8:7] == 2'h2) chk(out_temp_enable, rows[i][6]);
      end
      $display("config rows done");
      run(8'h00, 1'h0);
      run(8'h00, 1'h1);
      run(8'h07, 1'h0);
      $display("readout done");
      wm(12, 8'h00);
      wm(13, 8'h03);
      repeat (4) @(posedge sys_clk);
      chk(write_locked, 1);
      wr(8'h08, 32'h2);
      wr(8'h0c, 32'h1);
      rd(8'h04);
      chk(r[2], 1);
      rd(8'hfc);
      chk(r, 0);
      rd(8'h0c);
      chk(r, {24'h0, mem[2]});
      run(8'h00, 1'h1);
      chk(host.bad, 0);
      $display("lock test done");
      print_verdict;
   end
endmodule
`default_nettype wire
